// file: rtl/rcad_consts.vh
// Constants for the RISC core ALU datapath
`ifndef RCAD_CONSTS_VH
`define RCAD_CONSTS_VH
`define RCAD_IW 14
`define RCAD_DW 8
`define RCAD_PCW 13
`define RCAD_FAW 7
`define RCAD_PC_RESET 13'h0000
`define RCAD_STATUS_ADDR 7'h03
`define RCAD_PCL_ADDR 7'h02
`define RCAD_FSR_ADDR 7'h04
`define RCAD_INDF_ADDR 7'h00
`define RCAD_PCLATH_ADDR 7'h0A
`define RCAD_BIT_C 0
`define RCAD_BIT_DC 1
`define RCAD_BIT_Z 2
`define RCAD_NOP 14'h0000
`endif

// file: rtl/rcad_core.v
// Execution datapath of the small RISC core
`default_nettype none
`include "rcad_consts.vh"
module rcad_core (
  // Clock and resets
  input wire mclk_i,
  input wire rst_i,
  input wire master_clear_input_n_i,
  // Program memory
  output reg [`RCAD_PCW-1:0] prog_addr_o,
  input wire [`RCAD_IW-1:0] prog_data_i,
  // Status
  output wire quarter_rate_clock_output_o,
  output reg [`RCAD_DW-1:0] accumulator_o,
  output wire phase_one_o,
  output wire phase_two_o,
  output wire phase_four_o
);
  localparam PH1 = 2'd0;
  localparam PH2 = 2'd1;
  localparam PH3 = 2'd2;
  localparam PH4 = 2'd3;

  wire reset = rst_i | ~master_clear_input_n_i;

  reg [1:0] phase_reg;
  reg [`RCAD_PCW-1:0] pc_reg;
  reg [`RCAD_IW-1:0] ir_reg;
  reg [`RCAD_DW-1:0] w_reg;
  reg [`RCAD_DW-1:0] status_reg;
  reg [`RCAD_DW-1:0] fsr_reg;
  reg [4:0] pclath_reg;
  reg flush_reg;
  reg [`RCAD_DW-1:0] opnd_reg;

  // Four-phase divider; phases never overlap
  always @(posedge mclk_i) begin
    if (reset) begin
      phase_reg <= PH1;
    end else begin
      phase_reg <= phase_reg + 2'd1;
    end
  end
  assign phase_one_o = (phase_reg == PH1);
  assign phase_two_o = (phase_reg == PH2);
  assign phase_four_o = (phase_reg == PH4);
  // High during phases one and two, so one period per instruction cycle
  assign quarter_rate_clock_output_o = ~phase_reg[1];

  // Instruction fields: f-format and literal-format
  wire [5:0] opc = ir_reg[13:8];
  wire dst_f = ir_reg[7];
  wire [6:0] faddr = ir_reg[6:0];
  wire [7:0] lit = ir_reg[7:0];
  wire is_lit = (ir_reg[13:12] == 2'b11);
  wire is_goto = (ir_reg[13:12] == 2'b10);
  wire [3:0] lop = ir_reg[11:8];

  // Indirect access goes through the select register
  wire [6:0] eff_addr = (faddr == `RCAD_INDF_ADDR) ? fsr_reg[6:0] : faddr;

  function is_sfr;
    input [6:0] a;
    begin
      is_sfr = (a == `RCAD_PCL_ADDR) || (a == `RCAD_STATUS_ADDR) ||
               (a == `RCAD_FSR_ADDR) || (a == `RCAD_PCLATH_ADDR);
    end
  endfunction

  wire [7:0] ram_rdata;
  reg ram_we;
  reg [7:0] result;
  rcad_regfile #(.AW(`RCAD_FAW), .DW(`RCAD_DW)) u_ram (
    .mclk_i(mclk_i),
    .raddr_i(eff_addr),
    .rdata_o(ram_rdata),
    .we_i(ram_we),
    .waddr_i(eff_addr),
    .wdata_i(result)
  );

  // Special registers are read like file registers
  reg [7:0] file_val;
  always @* begin
    case (eff_addr)
      `RCAD_PCL_ADDR: file_val = pc_reg[7:0];
      `RCAD_STATUS_ADDR: file_val = status_reg;
      `RCAD_FSR_ADDR: file_val = fsr_reg;
      `RCAD_PCLATH_ADDR: file_val = {3'b000, pclath_reg};
      default: file_val = ram_rdata;
    endcase
  end

  // ALU: operand b is file or literal, operand a the accumulator
  wire [7:0] opb = is_lit ? lit : opnd_reg;
  wire [8:0] sum = {1'b0, w_reg} + {1'b0, opb};
  wire [4:0] nsum = {1'b0, w_reg[3:0]} + {1'b0, opb[3:0]};
  // Subtract b - W as b + ~W + 1: carry out is the inverted borrow
  wire [8:0] dif = {1'b0, opb} + {1'b0, ~w_reg} + 9'h001;
  wire [4:0] ndif = {1'b0, opb[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;
  reg c_new;
  reg dc_new;
  reg upd_c;
  reg upd_dc;
  reg upd_z;
  reg to_w;
  always @* begin
    result = 8'h00;
    c_new = status_reg[`RCAD_BIT_C];
    dc_new = status_reg[`RCAD_BIT_DC];
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    to_w = 1'b0;
    if (is_lit) begin
      to_w = 1'b1;
      case (lop)
        4'h0: result = lit;
        4'h8: begin result = w_reg | lit; upd_z = 1'b1; end
        4'h9: begin result = w_reg & lit; upd_z = 1'b1; end
        4'hA: begin result = w_reg ^ lit; upd_z = 1'b1; end
        4'hC: begin // subtract_accumulator_from_literal_op
          result = dif[7:0]; c_new = dif[8]; dc_new = ndif[4];
          upd_c = 1'b1; upd_dc = 1'b1; upd_z = 1'b1;
        end
        4'hE: begin
          result = sum[7:0]; c_new = sum[8]; dc_new = nsum[4];
          upd_c = 1'b1; upd_dc = 1'b1; upd_z = 1'b1;
        end
        default: result = w_reg;
      endcase
    end else begin
      to_w = ~dst_f;
      case (opc)
        6'h01: begin result = 8'h00; upd_z = 1'b1; end
        6'h02: begin // subtract_accumulator_from_file_op
          result = dif[7:0]; c_new = dif[8]; dc_new = ndif[4];
          upd_c = 1'b1; upd_dc = 1'b1; upd_z = 1'b1;
        end
        6'h03: begin result = opb - 8'h01; upd_z = 1'b1; end
        6'h04: begin result = w_reg | opb; upd_z = 1'b1; end
        6'h05: begin result = w_reg & opb; upd_z = 1'b1; end
        6'h06: begin result = w_reg ^ opb; upd_z = 1'b1; end
        6'h07: begin
          result = sum[7:0]; c_new = sum[8]; dc_new = nsum[4];
          upd_c = 1'b1; upd_dc = 1'b1; upd_z = 1'b1;
        end
        6'h08: begin result = opb; upd_z = 1'b1; end
        6'h09: begin result = ~opb; upd_z = 1'b1; end
        6'h0A: begin result = opb + 8'h01; upd_z = 1'b1; end
        6'h0C: begin // Rotate right through carry
          result = {status_reg[`RCAD_BIT_C], opb[7:1]}; c_new = opb[0]; upd_c = 1'b1;
        end
        6'h0D: begin // Rotate left through carry
          result = {opb[6:0], status_reg[`RCAD_BIT_C]}; c_new = opb[7]; upd_c = 1'b1;
        end
        6'h0E: result = {opb[3:0], opb[7:4]};
        // Opcode zero copies the accumulator out to a file register
        default: result = w_reg;
      endcase
    end
  end

  wire is_nop = (ir_reg == `RCAD_NOP);
  wire exec = ~flush_reg & ~is_nop & ~is_goto;
  wire wr_file = exec & ~is_lit & ~to_w;
  wire pc_write = wr_file & (eff_addr == `RCAD_PCL_ADDR);
  wire branch = ~flush_reg & (is_goto | pc_write);

  always @* begin
    ram_we = (phase_reg == PH4) & wr_file & ~is_sfr(eff_addr);
  end

  always @(posedge mclk_i) begin
    if (reset) begin
      pc_reg <= `RCAD_PC_RESET;
      prog_addr_o <= `RCAD_PC_RESET;
      ir_reg <= `RCAD_NOP;
      w_reg <= 8'h00;
      status_reg <= 8'h00;
      fsr_reg <= 8'h00;
      pclath_reg <= 5'h00;
      flush_reg <= 1'b0;
      opnd_reg <= 8'h00;
      accumulator_o <= 8'h00;
    end else begin
      case (phase_reg)
        PH2: begin
          // Address goes out before the step, so the reset vector and branch targets are fetched
          prog_addr_o <= pc_reg;
          pc_reg <= pc_reg + 13'h0001;
          opnd_reg <= file_val;
        end
        PH4: begin
          ir_reg <= branch ? `RCAD_NOP : prog_data_i;
          flush_reg <= branch;
          if (is_goto & ~flush_reg) begin
            pc_reg <= {pclath_reg[4:3], ir_reg[10:0]};
          end
          if (exec) begin
            if (to_w) begin
              w_reg <= result;
              accumulator_o <= result;
            end
            if (upd_c) status_reg[`RCAD_BIT_C] <= c_new;
            if (upd_dc) status_reg[`RCAD_BIT_DC] <= dc_new;
            if (upd_z) status_reg[`RCAD_BIT_Z] <= (result == 8'h00);
            if (wr_file) begin
              case (eff_addr)
                `RCAD_PCL_ADDR: pc_reg <= {pclath_reg, result};
                `RCAD_STATUS_ADDR: status_reg <= result;
                `RCAD_FSR_ADDR: fsr_reg <= result;
                `RCAD_PCLATH_ADDR: pclath_reg <= result[4:0];
                default: ;
              endcase
            end
          end
        end
        default: ;
      endcase
    end
  end
endmodule // rcad_core
`default_nettype wire

// file: rtl/rcad_regfile.v
// Data register file memory with registered read data
`default_nettype none
module rcad_regfile #(
  parameter AW = 7,
  parameter DW = 8
) (
  // Clock
  input wire mclk_i,
  // Read port
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o,
  // Write port
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // rcad_regfile
`default_nettype wire

// file: tb/rcad_chk_asserts.sv
// Port timing checks for the core datapath
`default_nettype none
module rcad_chk (
  // Clock and resets
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic master_clear_input_n_i,
  // Fetch and status
  input wire logic [12:0] prog_addr_o,
  input wire logic quarter_rate_clock_output_o,
  input wire logic [7:0] accumulator_o,
  input wire logic phase_one_o,
  input wire logic phase_two_o,
  input wire logic phase_four_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire rst = rst_i || !master_clear_input_n_i;
  wire p1 = phase_one_o;
  wire p2 = phase_two_o;
  wire p4 = phase_four_o;
  wire q = quarter_rate_clock_output_o;
  wire [12:0] pa = prog_addr_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst);
  phase_next_a: assert property (p1 |=> p2) else $error("phase order");
  phase_cycle_a: assert property (p2 |=> !p4 ##1 p4 ##1 p1) else $error("phase cycle");
  phase_excl_a: assert property ($onehot0({p1, p2, p4})) else $error("phase overlap");
  qclk_high_a: assert property (p1 || p2 |-> q) else $error("clock out low");
  qclk_low_a: assert property (!p1 && !p2 |-> !q) else $error("clock out high");
  addr_hold_a: assert property (p2 |=> ##1 $stable(pa)[*3]) else $error("pc moved");
  acc_write_a: assert property ($changed(accumulator_o) |-> $past(p4) || $past(rst))
    else $error("acc write off phase");
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    p1 && q && pa == 13'h0000 && accumulator_o == 8'h00) else $error("reset state");
  cover property (disable iff (1'b0) !master_clear_input_n_i);
  cover property (p4 ##1 $changed(accumulator_o));
  cover property (p2 ##1 $changed(pa));
endmodule // rcad_chk
bind rcad_core rcad_chk chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .master_clear_input_n_i(master_clear_input_n_i), .prog_addr_o(prog_addr_o),
  .quarter_rate_clock_output_o(quarter_rate_clock_output_o), .accumulator_o(accumulator_o),
  .phase_one_o(phase_one_o), .phase_two_o(phase_two_o), .phase_four_o(phase_four_o));
`default_nettype wire

// file: tb/rcad_progmem.sv
// Program memory model for the core fetch port
`default_nettype none
module rcad_progmem (
  // Fetch port
  input wire logic [12:0] addr_i,
  output logic [13:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [0:31];
  // Unused places read as no-op so a runaway fetch stays harmless
  assign data_o = (addr_i < 13'h0020) ? mem[addr_i[4:0]] : 14'h0000;
endmodule // rcad_progmem
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the core datapath
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic master_clear_input_n = 1'b1;
  logic [12:0] pa;
  logic [13:0] pd;
  logic [7:0] acc_o;
  logic [7:0] exp_q[$];
  logic [7:0] run_q[$];
  logic [7:0] acc = 8'h00;
  logic [7:0] acc_seen = 8'h00;
  logic [31:0] rnd = 32'd94179;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  rcad_core dut (.mclk_i(mclk_i), .rst_i(rst_i), .master_clear_input_n_i(master_clear_input_n),
    .prog_addr_o(pa), .prog_data_i(pd), .quarter_rate_clock_output_o(),
    .accumulator_o(acc_o), .phase_one_o(), .phase_two_o(), .phase_four_o());
  rcad_progmem pm (.addr_i(pa), .data_o(pd));
  initial forever #10 mclk_i = ~mclk_i;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic [13:0] lit(input logic [3:0] op, input logic [7:0] k);
    return {2'b11, op, k};
  endfunction
  task automatic put(input int a, input logic [13:0] w, input logic [7:0] e);
    pm.mem[a] = w;
    acc = e;
    run_q.push_back(e);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      give_verdict();
    end
  end
  // Sampled mid-cycle so a new value has settled before it is compared
  always @(negedge mclk_i) begin
    if (!rst_i && acc_o !== acc_seen) begin
      acc_seen = acc_o;
      check("acc", {8'h00, acc_o}, {8'h00, exp_q.size() ? exp_q.pop_front() : ~acc_o});
    end
  end
  initial begin
    for (int i = 0; i < 32; i++) pm.mem[i] = 14'h0000;
    put(0, lit(4'h0, 8'h55), 8'h55);
    put(1, lit(4'hE, 8'hAB), 8'h00);
    // Flags are only visible by moving the status register into the accumulator
    put(2, 14'h0803, 8'h07);
    put(3, lit(4'h8, 8'h0F), 8'h0F);
    put(4, lit(4'h9, 8'h3C), 8'h0C);
    put(5, lit(4'hA, 8'hFF), 8'hF3);
    put(6, lit(4'hC, 8'h10), 8'h1D);
    put(7, 14'h0803, 8'h00);
    put(8, lit(4'hC, 8'hFF), 8'hFF);
    put(9, 14'h0803, 8'h03);
    put(10, lit(4'h0, 8'h20), 8'h20);
    pm.mem[11] = 14'h0084;
    put(12, lit(4'h0, 8'h5A), 8'h5A);
    pm.mem[13] = 14'h0080;
    put(14, lit(4'h0, 8'h00), 8'h00);
    put(15, 14'h0820, 8'h5A);
    put(16, 14'h0802, 8'h11);
    pm.mem[17] = 14'h2013;
    pm.mem[18] = lit(4'h0, 8'h99);
    put(19, lit(4'h0, 8'h42), 8'h42);
    for (int i = 20; i < 28; i++) begin
      rnd = xs(rnd);
      put(i, lit(4'hE, rnd[7:0] | 8'h01), acc + (rnd[7:0] | 8'h01));
    end
    pm.mem[28] = 14'h201C;
    exp_q = run_q;
    repeat (5) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (200) @(posedge mclk_i);
    check("pending", 16'(exp_q.size()), 16'h0000);
    $display("program run done");
    if (acc !== 8'h00) exp_q.push_back(8'h00);
    foreach (run_q[i]) exp_q.push_back(run_q[i]);
    #1 master_clear_input_n = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 check("pc in reset", {3'b000, pa}, 16'h0000);
    master_clear_input_n = 1'b1;
    repeat (200) @(posedge mclk_i);
    check("pending", 16'(exp_q.size()), 16'h0000);
    $display("master clear run done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
